// [rtl/sfr_map.svh]
// constants and behaviour list for the serial fault-reporting slave
// Behaviour
// - at power-up hold fault status active at least one pulse, then release when pump ok, no faults (code: released when no fault enabled in maskReg)
// - after wake enable rises, fault status returns high within 1.0 ms
// - wake enable low: outputs high impedance and fault status driven low
// - power-down starts 8.0 to 11 us after wake enable falls; no early release
// - release fault status after power-down only when disable input also low
// - keep fault status active during power-down until supplies are off
// - full-duplex slave only, fixed clock polarity and phase, fixed 16-bit words
// - msb first over 16 clocks; sample input on falling, change output on rising
// - bits beyond the first 16 shift on through the serial output
// - clock count zero or not multiple of 16 discards frame, sets framing error
// - serial output returns register addressed by previous frame, captured at select fall
// - first transfer after enable rises returns the status register
// - data bits of a read frame are ignored
// - serial output driven only while select low, high impedance after select rises
// - each fault latches into the status register when detected and holds
// - latched fault clears only when gone and a clearing event occurs
// - falling edge on disable input clears faults no longer present
// - rising edge on wake enable clears faults no longer present
// - status write clears latched bits written as one, keeps zeros
// - a write to register address 00 records a framing error
// - command msb: one is write, zero is read
// - next two bits select id, status, mask, or configuration register
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH
`define SFR_CLK_PERIOD_PS     25000
`define SFR_PO_MIN_NS         1000
`define SFR_PO_CYC            ((`SFR_PO_MIN_NS * 1000 + `SFR_CLK_PERIOD_PS - 1) / `SFR_CLK_PERIOD_PS)
`define SFR_PD_MIN_NS         8000
`define SFR_PD_CYC            ((`SFR_PD_MIN_NS * 1000 + `SFR_CLK_PERIOD_PS - 1) / `SFR_CLK_PERIOD_PS)
`define SFR_TURN_ON_MAX_NS    1000000
`define SFR_TURN_ON_CYC       ((`SFR_TURN_ON_MAX_NS / 1000) * 1000 / (`SFR_CLK_PERIOD_PS / 1000))
`define SFR_WORD_BITS         16
`define SFR_DIR_BIT           15
`define SFR_ADDR_HI           14
`define SFR_ADDR_LO           13
`define SFR_FRM_BIT           11
`define SFR_FAULT_BITS        11
`define SFR_ADDR_ID           2'h0
`define SFR_ADDR_STATUS       2'h1
`define SFR_ADDR_MASK         2'h2
`define SFR_ADDR_CFG          2'h3
`define SFR_ID_VALUE          16'h0010
`define SFR_STATUS_HEAD       16'h2000
`define SFR_MASK_RESET        16'h4731
`define SFR_CFG_RESET         16'h6d98
`define SFR_MASK_WMASK        16'h1fff
`define SFR_CFG_WMASK         16'h1fff
`endif

// [rtl/sfr_pkg.sv]
// types for the serial fault-reporting slave
package sfr_pkg;
  typedef enum logic [1:0] {
    SFR_OFF     = 2'b00,
    SFR_POWERUP = 2'b01,
    SFR_RUN     = 2'b11,
    SFR_PWRDOWN = 2'b10
  } sfr_power_e;
  typedef logic [15:0] sfr_word_t;
endpackage : sfr_pkg

// [rtl/sfr_spi_fault_slave.sv]
// serial fault-reporting slave with fault-status pin sequencing
`timescale 1ns/1ps
`include "sfr_map.svh"
module sfr_spi_fault_slave #(
  parameter int TURN_ON_CYC = `SFR_TURN_ON_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        mosi,
  output logic             miso,
  output logic             misoOe,
  input  wire logic        wake_enable_pin,
  input  wire logic        disable_pin,
  input  wire logic [10:0] faultActive,
  input  wire logic        pumpOk,
  input  wire logic        suppliesOn,
  output logic             fault_status_n,
  output logic             fault_status_n_oe,
  output logic             outputsEnable,
  output logic             regulatorsOn,
  output logic [15:0]      maskReg,
  output logic [15:0]      cfgReg
);
  logic rst1Reg, rstSyncReg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst1Reg    <= 1'b0;
      rstSyncReg <= 1'b0;
    end else begin
      rst1Reg    <= 1'b1;
      rstSyncReg <= rst1Reg;
    end
  end
  wire rstnInt = rstSyncReg;

  // pin synchronisers: first stage read only by second
  logic [4:0] pinS1Reg, pinS2Reg, pinS3Reg;
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pinS1Reg <= 5'h01;
      pinS2Reg <= 5'h01;
      pinS3Reg <= 5'h01;
    end else if (clkEn) begin
      pinS1Reg <= {disable_pin, wake_enable_pin, mosi, sclk, csN};
      pinS2Reg <= pinS1Reg;
      pinS3Reg <= pinS2Reg;
    end
  end
  wire csS    = pinS2Reg[0];
  wire sclkS  = pinS2Reg[1];
  wire mosiS  = pinS2Reg[2];
  wire wakeS  = pinS2Reg[3];
  wire disS   = pinS2Reg[4];
  wire csFall   = pinS3Reg[0] & ~csS;
  wire csRise   = ~pinS3Reg[0] & csS;
  wire sclkRise = ~pinS3Reg[1] & sclkS;
  wire sclkFall = pinS3Reg[1] & ~sclkS;
  wire wakeRise = ~pinS3Reg[3] & wakeS;
  wire wakeFall = pinS3Reg[3] & ~wakeS;
  wire disFall  = pinS3Reg[4] & ~disS;

  // power sequencing
  sfr_pkg::sfr_power_e pwr_reg, pwr_next;
  logic [15:0] tmr_reg;
  wire [15:0] poCyc = 16'(`SFR_PO_CYC);
  wire [15:0] pdCyc = 16'(`SFR_PD_CYC);
  logic [10:0] flt_reg;
  logic        frm_reg;
  wire [11:0] statusBits = {frm_reg, flt_reg};
  wire maskedFault = |(statusBits & maskReg[11:0]);
  wire pwrReleased = (pwr_reg == sfr_pkg::SFR_RUN) & ~maskedFault;
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      sfr_pkg::SFR_OFF:     if (wakeS) pwr_next = sfr_pkg::SFR_POWERUP;
      // minimum active pulse before pump
      sfr_pkg::SFR_POWERUP: if (!wakeS) pwr_next = sfr_pkg::SFR_PWRDOWN;
                            else if (tmr_reg >= poCyc && pumpOk) pwr_next = sfr_pkg::SFR_RUN;
      sfr_pkg::SFR_RUN:     if (!wakeS) pwr_next = sfr_pkg::SFR_PWRDOWN;
      // held until delay elapsed, supplies off and disable low
      sfr_pkg::SFR_PWRDOWN: if (wakeS) pwr_next = sfr_pkg::SFR_POWERUP;
                            else if (tmr_reg >= pdCyc && !suppliesOn && !disS) pwr_next = sfr_pkg::SFR_OFF;
      default:              pwr_next = sfr_pkg::SFR_OFF;
    endcase
  end
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pwr_reg <= sfr_pkg::SFR_OFF;
      tmr_reg <= 16'h0000;
    end else if (clkEn) begin
      pwr_reg <= pwr_next;
      tmr_reg <= (pwr_next != pwr_reg) ? 16'h0000 : ((tmr_reg == 16'hffff) ? tmr_reg : tmr_reg + 16'h0001);
    end
  end

  // turn-on watch: cycles since wake without release, saturating
  // release still waits for the pump, so the bound only binds once it is up
  logic [15:0] onWait_reg;
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      onWait_reg <= 16'h0000;
    end else if (clkEn) begin
      if (!wakeS || pwrReleased) begin
        onWait_reg <= 16'h0000;
      end else if (onWait_reg != 16'hffff) begin
        onWait_reg <= onWait_reg + 16'h0001;
      end
    end
  end
  wire [15:0] onLimit = 16'(TURN_ON_CYC);

  // regulators stay on until the power-down delay has elapsed
  assign regulatorsOn = (pwr_reg == sfr_pkg::SFR_POWERUP) | (pwr_reg == sfr_pkg::SFR_RUN)
                      | ((pwr_reg == sfr_pkg::SFR_PWRDOWN) & (tmr_reg < pdCyc));
  // bridge off at once when wake drops
  assign outputsEnable     = (pwr_reg == sfr_pkg::SFR_RUN) & wakeS & ~maskedFault;
  // open drain: pulled low whenever not released
  assign fault_status_n    = 1'b0;
  assign fault_status_n_oe = ~pwrReleased | ~wakeS;

  // serial frame engine
  logic [15:0] shift_reg, txShift_reg, rxWord_reg;
  logic [15:0] txOut_reg;
  logic [7:0]  bitCnt_reg;
  logic        misoOut_reg;
  logic [1:0]  prevAddr_reg;
  logic        firstXfer_reg;
  logic [15:0] readBack;

  // status word layout shared by the reply mux and the first-transfer path
  function automatic logic [15:0] statusWordOf(input logic [11:0] bits);
    return `SFR_STATUS_HEAD | {4'h0, bits};
  endfunction : statusWordOf

  always_comb begin
    case (prevAddr_reg)
      `SFR_ADDR_ID:     readBack = `SFR_ID_VALUE;
      `SFR_ADDR_STATUS: readBack = statusWordOf(statusBits);
      `SFR_ADDR_MASK:   readBack = maskReg;
      default:          readBack = cfgReg;
    endcase
  end
  wire [15:0] statusWord = statusWordOf(statusBits);
  wire        replyMsb   = firstXfer_reg ? statusWord[15] : readBack[15];
  // whole number of words and nonzero
  wire frameValid = (bitCnt_reg != 8'h00) && (bitCnt_reg[3:0] == 4'h0);
  wire isWrite    = rxWord_reg[`SFR_DIR_BIT];
  wire [1:0] rxAddr = rxWord_reg[`SFR_ADDR_HI:`SFR_ADDR_LO];
  wire frameEnd   = csRise & frameValid;
  // address 00 is read-only
  wire badWrite   = frameEnd & isWrite & (rxAddr == `SFR_ADDR_ID);
  wire frameErr   = (csRise & ~frameValid) | badWrite;
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      shift_reg     <= 16'h0000;
      rxWord_reg    <= 16'h0000;
      txShift_reg   <= 16'h0000;
      bitCnt_reg    <= 8'h00;
      misoOut_reg   <= 1'b0;
      prevAddr_reg  <= `SFR_ADDR_STATUS;
      firstXfer_reg <= 1'b1;
    end else if (clkEn) begin
      if (wakeRise) begin
        firstXfer_reg <= 1'b1;
      end
      if (csFall) begin
        // reply chosen at select fall
        txShift_reg <= firstXfer_reg ? statusWord : readBack;
        bitCnt_reg  <= 8'h00;
        misoOut_reg <= firstXfer_reg ? statusWord[15] : readBack[15];
      end else if (!csS && sclkFall) begin
        // sample on falling edge, msb first
        shift_reg  <= {shift_reg[14:0], mosiS};
        txShift_reg <= {txShift_reg[14:0], mosiS};
        bitCnt_reg <= (bitCnt_reg == 8'hff) ? bitCnt_reg : bitCnt_reg + 8'h01;
        if (bitCnt_reg[3:0] == 4'hf) rxWord_reg <= {shift_reg[14:0], mosiS};
      end else if (!csS && sclkRise) begin
        // launch on rising edge; excess bits pass through
        misoOut_reg <= txShift_reg[15];
      end
      // a refused write to the id address must not move the reply pointer
      if (frameEnd & ~badWrite) begin
        prevAddr_reg  <= rxAddr;
        firstXfer_reg <= 1'b0;
      end
    end
  end
  assign miso   = misoOut_reg;
  // drive only while selected
  assign misoOe = ~csS & wakeS;

  // register writes at select rise of a valid frame
  wire wrMask = frameEnd & isWrite & (rxAddr == `SFR_ADDR_MASK);
  wire wrCfg  = frameEnd & isWrite & (rxAddr == `SFR_ADDR_CFG);
  wire wrStat = frameEnd & isWrite & (rxAddr == `SFR_ADDR_STATUS);
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      maskReg <= `SFR_MASK_RESET;
      cfgReg  <= `SFR_CFG_RESET;
    end else if (clkEn) begin
      if (!wakeS) begin
        maskReg <= `SFR_MASK_RESET;
        cfgReg  <= `SFR_CFG_RESET;
      end else begin
        if (wrMask) maskReg <= (maskReg & ~`SFR_MASK_WMASK) | (rxWord_reg & `SFR_MASK_WMASK);
        if (wrCfg)  cfgReg  <= (cfgReg & ~`SFR_CFG_WMASK) | (rxWord_reg & `SFR_CFG_WMASK);
      end
    end
  end

  // fault latching; a present fault always wins over a clear
  wire clrEvent = disFall | wakeRise;
  wire [10:0] clrBits = ({11{clrEvent}} | ({11{wrStat}} & rxWord_reg[10:0])) & ~faultActive;
  wire frmClr = (clrEvent | (wrStat & rxWord_reg[`SFR_FRM_BIT]));
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      flt_reg <= 11'h000;
      frm_reg <= 1'b0;
    end else if (clkEn) begin
      flt_reg <= (flt_reg & ~clrBits) | faultActive;
      frm_reg <= frameErr | (frm_reg & ~frmClr);
    end
  end

  // checks
  AST_PO_MIN: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && pwr_reg == sfr_pkg::SFR_POWERUP && pwr_next == sfr_pkg::SFR_RUN) |-> tmr_reg >= poCyc)
    else $error("status released before minimum pulse");

  AST_RELEASE: assert property (@(posedge clk) disable iff (!rstnInt)
    !fault_status_n_oe |-> (pwr_reg == sfr_pkg::SFR_RUN) && !maskedFault)
    else $error("status released outside run or with masked fault");

  AST_PUMP_RUN: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && pwr_reg == sfr_pkg::SFR_POWERUP && pwr_next == sfr_pkg::SFR_RUN) |-> pumpOk)
    else $error("run entered with pump low");

  AST_TURN_ON: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && wakeS && pumpOk && !maskedFault && onWait_reg >= onLimit) |-> ##[0:2] !fault_status_n_oe)
    else $error("status not returned high within turn-on time");

  AST_WAKE_LOW: assert property (@(posedge clk) disable iff (!rstnInt)
    !wakeS |-> fault_status_n_oe && !outputsEnable && !misoOe)
    else $error("outputs active with wake low");

  AST_RELOAD: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && !wakeS) |=> maskReg == `SFR_MASK_RESET && cfgReg == `SFR_CFG_RESET)
    else $error("defaults not reloaded in sleep");

  AST_PD_DELAY: assert property (@(posedge clk) disable iff (!rstnInt)
    (pwr_reg == sfr_pkg::SFR_PWRDOWN && pwr_next == sfr_pkg::SFR_OFF) |-> tmr_reg >= pdCyc)
    else $error("power-down ended early");

  AST_REG_HOLD: assert property (@(posedge clk) disable iff (!rstnInt)
    (pwr_reg == sfr_pkg::SFR_PWRDOWN && tmr_reg < pdCyc) |-> regulatorsOn)
    else $error("regulators dropped inside power-down delay");

  AST_PD_DIS: assert property (@(posedge clk) disable iff (!rstnInt)
    (pwr_reg == sfr_pkg::SFR_PWRDOWN && disS) |=> pwr_reg != sfr_pkg::SFR_OFF)
    else $error("power-down completed with disable high");

  AST_PD_SUPPLY: assert property (@(posedge clk) disable iff (!rstnInt)
    (pwr_reg == sfr_pkg::SFR_PWRDOWN && suppliesOn) |=> pwr_reg != sfr_pkg::SFR_OFF && fault_status_n_oe)
    else $error("status released while supplies on");

  AST_LAUNCH: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && !csS && sclkRise && !csFall) |=> miso == $past(txShift_reg[15]))
    else $error("serial output not launched on clock rise");

  AST_SAMPLE: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && !csS && sclkFall && !csFall) |=> txShift_reg[0] == $past(mosiS))
    else $error("input bit not taken on clock fall");

  AST_DISCARD: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && csRise && !frameValid) |=> $stable(prevAddr_reg))
    else $error("bad frame moved the reply pointer");

  AST_MISO_OE: assert property (@(posedge clk) disable iff (!rstnInt)
    csS |-> !misoOe)
    else $error("miso driven while deselected");

  AST_MISO_ON: assert property (@(posedge clk) disable iff (!rstnInt)
    (!csS && wakeS) |-> misoOe)
    else $error("miso not driven while selected");

  AST_FRM_SET: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && csRise && !frameValid) |=> frm_reg)
    else $error("framing error not recorded");

  AST_MISO_LOAD: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && csFall) |=> miso == $past(replyMsb))
    else $error("reply not loaded at select fall");

  AST_FIRST: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && wakeRise) |=> firstXfer_reg)
    else $error("first transfer not marked after wake");

  AST_READ_IGNORE: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && wakeS && frameEnd && !isWrite) |=> $stable(cfgReg) && $stable(maskReg))
    else $error("read frame changed a register");

  AST_LATCH: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && |faultActive) |=> ((flt_reg & $past(faultActive)) == $past(faultActive)))
    else $error("active fault not latched");

  AST_KEEP: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && !clrEvent && !wrStat) |=> (flt_reg & $past(flt_reg)) == $past(flt_reg))
    else $error("latched fault lost without a clear");

  AST_DIS_CLEAR: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && disFall) |=> flt_reg == $past(faultActive))
    else $error("disable fall did not clear gone faults");

  AST_WAKE_CLEAR: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && wakeRise) |=> flt_reg == $past(faultActive))
    else $error("wake rise did not clear gone faults");

  AST_WR_CLEAR: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && wrStat) |=> (flt_reg & $past(rxWord_reg[10:0]) & ~$past(faultActive)) == 11'h000)
    else $error("status write left a one-written gone fault");

  AST_FRM_CLEAR: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && wrStat && rxWord_reg[`SFR_FRM_BIT] && !frameErr) |=> !frm_reg)
    else $error("framing flag not cleared by write");

  AST_WR_APPLY: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && wakeS && !wrMask) |=> $stable(maskReg) || !$past(wakeS))
    else $error("mask changed outside valid frame end");

  AST_ID_WRITE: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && badWrite) |=> frm_reg)
    else $error("write to id not flagged");

  AST_ADDR: assert property (@(posedge clk) disable iff (!rstnInt)
    (clkEn && frameEnd && !badWrite) |=> prevAddr_reg == $past(rxAddr))
    else $error("reply pointer not taken from frame");

  COV_FRAME: cover property (@(posedge clk) disable iff (!rstnInt) frameEnd);
  COV_BADWR: cover property (@(posedge clk) disable iff (!rstnInt) badWrite);
  COV_BADFRM: cover property (@(posedge clk) disable iff (!rstnInt) csRise && !frameValid);
  COV_RUN: cover property (@(posedge clk) disable iff (!rstnInt) pwr_reg == sfr_pkg::SFR_RUN);
  COV_PD: cover property (@(posedge clk) disable iff (!rstnInt)
    pwr_reg == sfr_pkg::SFR_PWRDOWN ##1 pwr_reg == sfr_pkg::SFR_OFF);
endmodule : sfr_spi_fault_slave

// [tb/sfr_host_model.sv]
// host-side serial master model that frames words into the slave
`timescale 1ns/1ps
module sfr_host_model (
  input  wire logic        clk,
  input  wire logic        miso,
  input  wire logic        misoOe,
  output logic             csN,
  output logic             sclk,
  output logic             mosi,
  output logic [15:0]      rxWord,
  output logic             rxValid
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rxWord = 16'h0000;
    rxValid = 1'b0;
  end

  task automatic frame(input logic [15:0] w, input int n);
    logic [15:0] sh;
    sh = 16'h0000;
    @(posedge clk);
    csN <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;                      // launch on rise, idle low
      mosi <= w[15 - (i % 16)];          // msb first
      repeat (4) @(posedge clk);         // 5 MHz, below the ceiling
      sclk <= 1'b0;
      sh = {sh[14:0], miso};             // read on fall
      repeat (4) @(posedge clk);
    end
    csN <= 1'b1;
    mosi <= ~mosi;                       // released line must not keep a stale bit
    rxWord <= sh;
    rxValid <= 1'b1;
    @(posedge clk);
    rxValid <= 1'b0;
    repeat (14) @(posedge clk);          // idle gap above 300 ns
  endtask : frame
endmodule : sfr_host_model

// [tb/test_spi_fault_reporting_slave.sv]
// self-checking bench for the serial fault-reporting slave
`timescale 1ns/1ps
module test_spi_fault_reporting_slave;
  localparam logic [16:0] IGN = 17'h10000;
  logic        clk, rstn, csN, sclk, mosi, miso, misoOe, wakeEn, disPin, pumpOk, suppliesOn;
  logic        fsN, fsOe, outEn, regOn, rxValid;
  logic [10:0] faultActive;
  logic [15:0] maskReg, cfgReg, rxWord, d, seed;
  logic [16:0] e;
  logic [16:0] expQ[$];
  int          miscompares, totalChecks;

  sfr_spi_fault_slave dut (.clk(clk), .rstn(rstn), .clkEn(1'b1), .csN(csN), .sclk(sclk), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .wake_enable_pin(wakeEn), .disable_pin(disPin),
    .faultActive(faultActive), .pumpOk(pumpOk), .suppliesOn(suppliesOn), .fault_status_n(fsN),
    .fault_status_n_oe(fsOe), .outputsEnable(outEn), .regulatorsOn(regOn), .maskReg(maskReg),
    .cfgReg(cfgReg));
  sfr_host_model host (.clk(clk), .miso(miso), .misoOe(misoOe), .csN(csN), .sclk(sclk), .mosi(mosi),
    .rxWord(rxWord), .rxValid(rxValid));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] xs(input logic [15:0] x);
    x = x ^ (x << 7);
    x = x ^ (x >> 9);
    x = x ^ (x << 8);
    return x;
  endfunction : xs

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    if (miscompares == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic send(input logic [15:0] cmd, input logic [16:0] ex, input int n = 16);
    expQ.push_back(ex);
    host.frame(cmd, n);
    check({15'h0000, misoOe}, 16'h0000); // output released after select rises
  endtask : send

  // replies are compared in order against the notes left by the driver
  always @(posedge clk) begin
    if (rxValid === 1'b1) begin
      e = expQ.pop_front();
      if (!e[16]) check(rxWord, e[15:0]);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    wakeEn = 1'b0;
    disPin = 1'b1;
    pumpOk = 1'b0;
    suppliesOn = 1'b1;
    faultActive = 11'h000;
    seed = 16'h438f;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    wakeEn <= 1'b1;
    repeat (20) @(posedge clk);
    check({15'h0000, fsOe}, 16'h0001);   // status pulse held at power-up
    repeat (80) @(posedge clk);
    check({15'h0000, fsOe}, 16'h0001);   // pump still low keeps it active
    pumpOk <= 1'b1;
    repeat (20) @(posedge clk);
    check({15'h0000, fsOe}, 16'h0000);   // released once pump ok
    send(16'h4000, 17'h02000);           // first reply is status
    send(16'h6000, 17'h04731);           // reply from previous address
    seed = xs(seed);
    d = seed;
    send({3'h7, d[12:0]}, 17'h06d98);    // write configuration
    repeat (2) @(posedge clk);
    check(cfgReg, {3'h3, d[12:0]});      // applied at select rise
    send(16'h3fff, {4'h0, 3'h3, d[12:0]}); // status read with data bits set
    send(16'h8000, 17'h02000);           // write to read-only address
    send(16'h2000, IGN);
    send(16'ha800, 17'h02800);           // framing flag recorded
    send(16'h2000, 17'h02000);           // write-one cleared it
    send(16'h2000, IGN, 8);
    send(16'h0000, 17'h02800);           // short frame flagged
    send(16'h2000, 17'h00010);           // identification register
    faultActive <= 11'h008;
    repeat (4) @(posedge clk);
    faultActive <= 11'h000;
    send(16'h2000, 17'h02808);           // brief fault latched
    send(16'ha800, 17'h02808);
    send(16'h2000, 17'h02008);           // zero-written bit kept
    disPin <= 1'b0;
    repeat (50) @(posedge clk);
    send(16'h2000, 17'h02000);           // disable fall clears
    faultActive <= 11'h400;
    disPin <= 1'b1;
    repeat (50) @(posedge clk);
    disPin <= 1'b0;
    repeat (50) @(posedge clk);
    check({15'h0000, fsOe}, 16'h0001);   // masked fault drives status
    send(16'h2000, 17'h02400);           // present fault survives clear
    faultActive <= 11'h000;
    wakeEn <= 1'b0;
    repeat (10) @(posedge clk);
    check({14'h0000, fsOe, outEn}, 16'h0002); // sleep: outputs off, status low
    check({15'h0000, fsN}, 16'h0000);    // open drain only ever pulls low
    repeat (200) @(posedge clk);
    check({15'h0000, fsOe}, 16'h0001);   // still active inside power-down
    check({15'h0000, regOn}, 16'h0001);  // regulators kept through the delay
    suppliesOn <= 1'b0;
    repeat (200) @(posedge clk);
    check({15'h0000, regOn}, 16'h0000);  // power-down done with disable low
    check(maskReg, 16'h4731);            // mask, never written, still at its default in sleep
    suppliesOn <= 1'b1;
    wakeEn <= 1'b1;
    repeat (100) @(posedge clk);
    check({15'h0000, fsOe}, 16'h0000);   // back high after wake
    send(16'h2000, 17'h02000);           // wake rise cleared, status first
    finish_test();
  end
endmodule : test_spi_fault_reporting_slave
